// ===== include/range_guard_pkg.sv
// Shared types and constants for the travel range guard.
// Assumes positions are signed 32-bit counts sampled on the control clock.
package range_guard_pkg;

    localparam int POS_W = 32;
    localparam logic [9:0] MARGIN_MAX = 10'h3E8;
    localparam logic [9:0] MARGIN_RST = 10'h00A;
    localparam logic [1:0] STOP_SEQ_RST = 2'h0;

    // Control mode encoding seen on mode_i
    typedef enum logic [1:0] {
        MODE_POSITION = 2'h0,
        MODE_VELOCITY = 2'h1,
        MODE_TORQUE = 2'h2,
        MODE_FULL_CLOSED = 2'h3
    } ctrl_mode_t;

    // One-hot alarm sequencer states
    typedef enum logic [2:0] {
        ST_WATCH = 3'h1,
        ST_DECEL = 3'h2,
        ST_STOPPED = 3'h4
    } guard_state_t;

    // Drive condition flags that arrive together
    typedef struct packed {
        logic servo_on;
        logic dev_clear;
        logic trial_toggle;
        logic pos_init;
        logic freq_resp;
    } drive_cond_t;

    // Position command sample
    typedef struct packed {
        logic valid;
        logic signed [POS_W-1:0] delta;
    } pos_cmd_t;

endpackage : range_guard_pkg

// ===== logic/span_tracker.sv
// Command span tracker: holds how far commands have reached each side.
// Assumes deltas arrive on the same clock; clear is synchronous.
`timescale 1ns/1ps
module span_tracker (
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic reset_n_i,
    // Control
    input wire logic clear_i,
    input wire range_guard_pkg::pos_cmd_t cmd_i,
    // Span outputs, relative to the reference point
    output logic signed [range_guard_pkg::POS_W-1:0] cmd_sum_o,
    output logic signed [range_guard_pkg::POS_W-1:0] span_hi_o,
    output logic signed [range_guard_pkg::POS_W-1:0] span_lo_o
);
    import range_guard_pkg::*;

    logic signed [POS_W-1:0] sum_nxt;
    logic signed [POS_W-1:0] hi_nxt;
    logic signed [POS_W-1:0] lo_nxt;

    // Running command sum, then widen the span in either direction
    assign sum_nxt = cmd_sum_o + cmd_i.delta;
    assign hi_nxt = (sum_nxt > span_hi_o) ? sum_nxt : span_hi_o;
    assign lo_nxt = (sum_nxt < span_lo_o) ? sum_nxt : span_lo_o;

    // Power-up clears via reset; clear_i holds the span at zero
    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            cmd_sum_o <= '0;
            span_hi_o <= '0;
            span_lo_o <= '0;
        end else if (clear_i) begin
            cmd_sum_o <= '0;
            span_hi_o <= '0;
            span_lo_o <= '0;
        end else if (cmd_i.valid) begin
            cmd_sum_o <= sum_nxt;
            span_hi_o <= hi_nxt;
            span_lo_o <= lo_nxt;
        end
    end

    span_zero_a: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
        clear_i |=> (span_hi_o == 0 && span_lo_o == 0 && cmd_sum_o == 0))
        else $error("span not zero after clear");

    span_order_a: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
        span_lo_o <= cmd_sum_o && cmd_sum_o <= span_hi_o)
        else $error("command sum outside span");

endmodule : span_tracker

// ===== logic/motor_travel_range_guard.sv
// Travel range guard: alarms when the motor leaves the commanded span
// widened by a margin, then runs the alarm stop sequence.
// Assumes all status inputs come from logic on core_clk_i; positions in counts.
`timescale 1ns/1ps
module motor_travel_range_guard (
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic reset_n_i,
    // Drive status
    input wire range_guard_pkg::ctrl_mode_t mode_i,
    input wire range_guard_pkg::drive_cond_t cond_i,
    input wire logic alarm_clear_i,
    // Configuration
    input wire logic [9:0] working_range_margin_i,
    input wire logic [1:0] alarm_stop_sequence_i,
    input wire logic margin_load_i,
    // Position command and feedback
    input wire range_guard_pkg::pos_cmd_t cmd_i,
    input wire logic signed [range_guard_pkg::POS_W-1:0] motor_pos_i,
    input wire logic motor_stopped_i,
    // Alarm and stop outputs
    output logic software_limit_alarm_o,
    output logic decel_req_o,
    output logic [1:0] stop_seq_o,
    output logic stopped_o
);
    import range_guard_pkg::*;

    localparam int EXT_W = POS_W + 2;

    guard_state_t state_r;
    guard_state_t state_nxt;
    logic [9:0] margin_r;
    logic trial_r;
    logic signed [POS_W-1:0] ref_pos_r;
    logic alarm_r;
    logic decel_r;
    logic [1:0] seq_r;
    logic stopped_r;
    logic signed [POS_W-1:0] cmd_sum;
    logic signed [POS_W-1:0] span_hi;
    logic signed [POS_W-1:0] span_lo;
    logic signed [EXT_W-1:0] win_hi;
    logic signed [EXT_W-1:0] win_lo;
    logic signed [EXT_W-1:0] pos_ext;
    logic trial_edge;
    logic mode_pos;
    logic span_clear;
    logic check_en;
    logic outside;
    logic margin_ok;

    // Qualifying conditions for the check and for span clearing
    assign mode_pos = (mode_i == MODE_POSITION) || (mode_i == MODE_FULL_CLOSED);
    assign trial_edge = cond_i.trial_toggle ^ trial_r;
    assign span_clear = cond_i.dev_clear || !cond_i.servo_on || !mode_pos
        || trial_edge || cond_i.pos_init;
    assign check_en = mode_pos && cond_i.servo_on && !cond_i.freq_resp;
    assign margin_ok = working_range_margin_i <= MARGIN_MAX;

    // Window is span around the reference point plus margin each side;
    // with no commands the span is zero, so it is margin around position
    assign win_hi = EXT_W'(ref_pos_r) + EXT_W'(span_hi) + EXT_W'($signed({1'b0, margin_r}));
    assign win_lo = EXT_W'(ref_pos_r) + EXT_W'(span_lo) - EXT_W'($signed({1'b0, margin_r}));
    assign pos_ext = EXT_W'(motor_pos_i);
    assign outside = check_en && ((pos_ext > win_hi) || (pos_ext < win_lo));

    // Span starts empty at power-up through the shared reset
    span_tracker u_span (
        .core_clk_i(core_clk_i),
        .reset_n_i(reset_n_i),
        .clear_i(span_clear),
        .cmd_i(cmd_i),
        .cmd_sum_o(cmd_sum),
        .span_hi_o(span_hi),
        .span_lo_o(span_lo)
    );

    // Alarm stop sequencer
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            ST_WATCH: begin
                if (outside) begin
                    state_nxt = ST_DECEL;
                end
            end
            ST_DECEL: begin
                if (motor_stopped_i) begin
                    state_nxt = ST_STOPPED;
                end
            end
            ST_STOPPED: begin
                if (alarm_clear_i) begin
                    state_nxt = ST_WATCH;
                end
            end
            default: begin
                state_nxt = ST_WATCH;
            end
        endcase
    end

    // Margin is taken only when in range; out-of-range loads are ignored
    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            margin_r <= MARGIN_RST;
        end else if (margin_load_i && margin_ok) begin
            margin_r <= working_range_margin_i;
        end
    end

    // Reference point follows the motor while the span is cleared
    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            ref_pos_r <= '0;
            trial_r <= 1'b0;
        end else begin
            trial_r <= cond_i.trial_toggle;
            if (span_clear) begin
                ref_pos_r <= motor_pos_i;
            end
        end
    end

    // Sequencer state and registered outputs
    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            state_r <= ST_WATCH;
            alarm_r <= 1'b0;
            decel_r <= 1'b0;
            seq_r <= STOP_SEQ_RST;
            stopped_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            alarm_r <= (state_nxt != ST_WATCH);
            decel_r <= (state_nxt == ST_DECEL);
            stopped_r <= (state_nxt == ST_STOPPED);
            if (state_r == ST_WATCH && outside) begin
                seq_r <= alarm_stop_sequence_i;
            end
        end
    end

    // Cheap trade: outputs mirror flops, one cycle after the trip
    assign software_limit_alarm_o = alarm_r;
    assign decel_req_o = decel_r;
    assign stop_seq_o = seq_r;
    assign stopped_o = stopped_r;

    // Checks on the trip, the gating conditions and the captured sequence
    alarm_trip_a: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
        (state_r == ST_WATCH && outside) |=> software_limit_alarm_o && decel_req_o)
        else $error("alarm missed on window exit");

    mode_gate_a: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
        (state_r == ST_WATCH && !check_en) |=> !software_limit_alarm_o)
        else $error("alarm outside qualifying mode");

    freq_block_a: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
        (cond_i.freq_resp && state_r == ST_WATCH) |=> !decel_req_o)
        else $error("alarm during frequency response");

    margin_range_a: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
        margin_r <= MARGIN_MAX)
        else $error("margin beyond range");

    stop_seq_a: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
        (state_r == ST_WATCH && outside) |=> stop_seq_o == $past(alarm_stop_sequence_i))
        else $error("stop sequence not captured");

    alarm_hold_a: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
        (software_limit_alarm_o && !alarm_clear_i) |=> software_limit_alarm_o)
        else $error("alarm dropped without clear");

    vel_clear_a: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
        (!mode_pos) |=> (span_hi == 0 && span_lo == 0))
        else $error("span kept in velocity or torque");

    trial_clear_a: assert property (@(posedge core_clk_i)
        disable iff (!reset_n_i) ($changed(cond_i.trial_toggle) || cond_i.pos_init)
        |=> (cmd_sum == 0 && span_hi == 0))
        else $error("span not cleared on trial or init");

    // Checks on the stop handshake, the alarm release and the margin load
    stop_done_a: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
        (state_r == ST_DECEL && motor_stopped_i) |=> (stopped_o && !decel_req_o))
        else $error("stop not reported after motor halt");

    clear_refused_a: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
        (state_r == ST_DECEL && alarm_clear_i) |=> software_limit_alarm_o)
        else $error("alarm cleared while still decelerating");

    alarm_release_a: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
        (state_r == ST_STOPPED && alarm_clear_i) |=> (!software_limit_alarm_o && !stopped_o))
        else $error("alarm not released by clear");

    ref_follow_a: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
        span_clear |=> (ref_pos_r == $past(motor_pos_i)))
        else $error("reference not following motor");

    dev_clear_a: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
        (cond_i.dev_clear || !cond_i.servo_on) |=> (cmd_sum == 0 && span_lo == 0 && span_hi == 0))
        else $error("span kept while deviation cleared");

    margin_take_a: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
        (margin_load_i && margin_ok) |=> (margin_r == $past(working_range_margin_i)))
        else $error("legal margin not taken");

    margin_keep_a: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
        (margin_load_i && !margin_ok) |=> (margin_r == $past(margin_r)))
        else $error("illegal margin taken");

endmodule : motor_travel_range_guard

// ===== bench/drive_far_side.sv
// Far-side model: host command source and motor position feedback.
// Assumes bench requests change just after the rising edge.
`timescale 1ns/1ps
module drive_far_side (
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic reset_n_i,
    // Bench requests
    input wire logic cmd_go_i,
    input wire logic signed [31:0] cmd_delta_i,
    input wire logic signed [31:0] pos_req_i,
    input wire logic decel_req_i,
    // Toward the guard
    output range_guard_pkg::pos_cmd_t cmd_o,
    output logic signed [31:0] motor_pos_o,
    output logic motor_stopped_o
);
    import range_guard_pkg::*;
    logic [3:0] brake_r;
    // Delta is inverted between commands so a stale value never looks held
    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            cmd_o <= '0;
            motor_pos_o <= '0;
            brake_r <= 4'h0;
        end else begin
            cmd_o.valid <= cmd_go_i;
            cmd_o.delta <= cmd_go_i ? cmd_delta_i : ~cmd_o.delta;
            motor_pos_o <= pos_req_i;
            brake_r <= !decel_req_i ? 4'h0 : (brake_r == 4'hC) ? brake_r : brake_r + 4'h1;
        end
    end
    // A slow brake: the motor reports stopped twelve cycles into a stop
    assign motor_stopped_o = (brake_r == 4'hC);
endmodule : drive_far_side

// ===== bench/tb_motor_travel_range_guard.sv
// Bench for the travel range guard, driven through the far-side model.
// Assumes a 100 ns clock and the margin reset value of the package.
`timescale 1ns/1ps
module tb_motor_travel_range_guard;
    import range_guard_pkg::*;
    logic core_clk_i = 0;
    logic reset_n_i = 0;
    ctrl_mode_t mode = MODE_POSITION;
    drive_cond_t cond = '0;
    logic clr = 0, ld = 0, go = 0;
    logic [9:0] margin = 10'h00A;
    logic [1:0] seq = 2'h2;
    logic signed [31:0] delta = '0, pos = '0, mpos;
    pos_cmd_t cmd;
    logic mstop, alarm, decel, stopped;
    logic [1:0] sseq;
    int failures = 0, check_count = 0;
    initial begin
        forever #50 core_clk_i = ~core_clk_i;
    end
    motor_travel_range_guard i_dut (.core_clk_i(core_clk_i), .reset_n_i(reset_n_i),
        .mode_i(mode), .cond_i(cond), .alarm_clear_i(clr),
        .working_range_margin_i(margin), .alarm_stop_sequence_i(seq),
        .margin_load_i(ld), .cmd_i(cmd), .motor_pos_i(mpos), .motor_stopped_i(mstop),
        .software_limit_alarm_o(alarm), .decel_req_o(decel), .stop_seq_o(sseq),
        .stopped_o(stopped));
    drive_far_side i_far (.core_clk_i(core_clk_i), .reset_n_i(reset_n_i),
        .cmd_go_i(go), .cmd_delta_i(delta), .pos_req_i(pos), .decel_req_i(decel),
        .cmd_o(cmd), .motor_pos_o(mpos), .motor_stopped_o(mstop));
    task automatic report_and_stop();
        if (failures == 0 && check_count > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : report_and_stop
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e) begin
            $display("unexpected %s exp %0h got %0h", n, e, g);
            failures++;
        end
    endtask : chk
    task automatic tick(input int n);
        repeat (n) @(posedge core_clk_i);
    endtask : tick
    // Move the motor, let feedback and the window settle, judge the alarm
    task automatic see(input logic signed [31:0] p, input logic e);
        pos <= p;
        tick(5);
        chk("alarm", {31'h0, e}, {31'h0, alarm});
    endtask : see
    // Servo off at p latches p as the reference with an empty span
    task automatic arm(input logic signed [31:0] p);
        cond.servo_on <= 1'b0;
        pos <= p;
        tick(4);
        cond.servo_on <= 1'b1;
        tick(2);
    endtask : arm
    task automatic send(input logic signed [31:0] d);
        delta <= d;
        go <= 1'b1;
        tick(1);
        go <= 1'b0;
        tick(1);
    endtask : send
    task automatic load(input logic [9:0] m);
        margin <= m;
        ld <= 1'b1;
        tick(1);
        ld <= 1'b0;
        tick(1);
    endtask : load
    task automatic recover();
        cond.servo_on <= 1'b0;
        for (int i = 0; i < 40 && stopped !== 1'b1; i++) tick(1);
        chk("stopped", 32'h1, {31'h0, stopped});
        if (stopped !== 1'b1) report_and_stop();
        chk("decel", 32'h0, {31'h0, decel});
        clr <= 1'b1;
        tick(1);
        clr <= 1'b0;
        tick(2);
        chk("alarm", 32'h0, {31'h0, alarm});
    endtask : recover
    task automatic s_trip();
        arm(1000);
        see(1010, 1'b0);
        see(990, 1'b0);
        see(989, 1'b1);
        chk("stop_seq", 32'h2, {30'h0, sseq});
        chk("decel", 32'h1, {31'h0, decel});
        clr <= 1'b1;
        tick(1);
        clr <= 1'b0;
        see(1000, 1'b1);
        recover();
    endtask : s_trip
    task automatic s_span();
        arm(0);
        send(50);
        send(-80);
        see(60, 1'b0);
        see(-40, 1'b0);
        see(-41, 1'b1);
        recover();
    endtask : s_span
    task automatic s_margin();
        mode <= MODE_FULL_CLOSED;
        seq <= 2'h1;
        load(10'h3E8);
        arm(0);
        see(1000, 1'b0);
        see(-1000, 1'b0);
        load(10'h3E9);
        see(1001, 1'b1);
        chk("stop_seq", 32'h1, {30'h0, sseq});
        recover();
        load(10'h00A);
        mode <= MODE_POSITION;
    endtask : s_margin
    task automatic s_suppress();
        arm(0);
        for (int k = 0; k < 3; k++) begin
            if (k == 0) mode <= MODE_VELOCITY;
            if (k == 1) mode <= MODE_TORQUE;
            if (k == 2) begin
                mode <= MODE_POSITION;
                cond.freq_resp <= 1'b1;
            end
            see(500, 1'b0);
            see(0, 1'b0);
        end
        cond.freq_resp <= 1'b0;
    endtask : s_suppress
    // Each clear kind but servo off must drop a widened span back to the margin alone
    task automatic s_clears();
        for (int k = 0; k < 6; k++) begin
            arm(0);
            send(50);
            if (k == 0) cond.dev_clear <= 1'b1;
            if (k == 1) mode <= MODE_VELOCITY;
            if (k == 2 || k == 5) cond.trial_toggle <= ~cond.trial_toggle;
            if (k == 3) cond.pos_init <= 1'b1;
            if (k == 4) mode <= MODE_TORQUE;
            tick(3);
            cond.dev_clear <= 1'b0;
            cond.pos_init <= 1'b0;
            mode <= MODE_POSITION;
            tick(2);
            see(50, 1'b1);
            recover();
        end
    endtask : s_clears
    initial begin
        tick(20);
        reset_n_i <= 1'b1;
        tick(1);
        s_trip();
        s_span();
        s_margin();
        s_suppress();
        s_clears();
        report_and_stop();
    end
endmodule : tb_motor_travel_range_guard
